// file: design/gpio_port_pkg.sv
/*
  Constants and types shared by the GPIO port pin-control block.
  Assumes a single 125 MHz core clock and a synchronous active-high reset.
*/
package gpio_port_pkg;

  localparam int PIN_COUNT = 8;

  // Pin control mode, two bits per pin
  typedef enum logic [1:0] {
    MODE_SW_IN  = 2'h0,
    MODE_SW_OUT = 2'h1,
    MODE_HW     = 2'h2
  } pin_mode_type;

  // Interrupt detection, three bits per pin
  typedef enum logic [2:0] {
    DET_FALLING = 3'h0,
    DET_RISING  = 3'h1,
    DET_BOTH    = 3'h2,
    DET_LOW     = 3'h3,
    DET_HIGH    = 3'h4
  } detect_type;

  // Drive strength code, two bits per pin; slew control exists only with 8 mA
  typedef enum logic [1:0] {
    DRIVE_2MA    = 2'h0,
    DRIVE_4MA    = 2'h1,
    DRIVE_8MA    = 2'h2,
    DRIVE_8MA_SC = 2'h3
  } drive_type;

  // Per-pin configuration commands
  typedef enum logic [3:0] {
    CMD_NONE       = 4'h0,
    CMD_DIR_MODE   = 4'h1,
    CMD_INT_TYPE   = 4'h2,
    CMD_PAD_CFG    = 4'h3,
    CMD_INT_ENABLE = 4'h4,
    CMD_INT_DISABLE= 4'h5,
    CMD_INT_CLEAR  = 4'h6,
    CMD_ADC_ENABLE = 4'h7,
    CMD_ADC_DISABLE= 4'h8,
    CMD_ALT_SELECT = 4'h9,
    CMD_GPIO_SELECT= 4'ha
  } command_type;

  // Values after reset
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [2:0] DETECT_RESET = 3'h0;
  localparam logic [1:0] DRIVE_RESET = 2'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;

  // Data access address: the pin-select mask sits in address bits [9:2]
  localparam int DATA_ADDR_WIDTH = 10;
  localparam int MASK_ADDR_LSB = 2;

  // Read latency of the data port, in clock cycles
  localparam int READ_LATENCY_CYCLES = 1;

endpackage : gpio_port_pkg

// file: design/gpio_pin_slice.sv
/*
  One pin of the GPIO port: pin synchroniser, pad control and event detection.
  Assumes the configuration inputs come from the same clock domain.
*/
module gpio_pin_slice (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Configuration
  input wire logic [1:0] mode_i,
  input wire logic [2:0] detect_i,
  input wire logic open_drain_i,
  input wire logic sw_data_i,
  input wire logic hw_out_i,
  input wire logic hw_oe_i,
  input wire logic alt_select_i,
  input wire logic int_clear_i,
  // Pad
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o,
  // State
  output logic level_o,
  output logic raw_status_o
);
  import gpio_port_pkg::*;

  logic [2:0] warm_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic edge_flag_reg;
  logic rise;
  logic fall;
  logic edge_hit;
  logic drive_value;
  logic drive_enable;

  // Two flops before any logic sees the pad
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= pad_i;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  // Edges wait until both synchroniser flops and the previous-value flop hold pad
  // samples, so a pin that idles high gives no false edge after reset
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      warm_reg <= 3'h0;
    end else begin
      warm_reg <= {warm_reg[1:0], 1'b1};
    end
  end

  assign rise = warm_reg[2] & sync2_reg & ~prev_reg;
  assign fall = warm_reg[2] & ~sync2_reg & prev_reg;

  always_comb begin
    case (detect_i)
      DET_FALLING: edge_hit = fall;
      DET_RISING: edge_hit = rise;
      DET_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  end

  // Edges latch until cleared; a new edge in the clear cycle wins
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      edge_flag_reg <= 1'b0;
    end else if (edge_hit) begin
      edge_flag_reg <= 1'b1;
    end else if (int_clear_i) begin
      edge_flag_reg <= 1'b0;
    end
  end

  // Level types follow the pin directly in software input mode and read zero in other modes, so clear has no lasting effect on them
  always_comb begin
    case (detect_i)
      DET_LOW: raw_status_o = ~sync2_reg & (mode_i == MODE_SW_IN);
      DET_HIGH: raw_status_o = sync2_reg & (mode_i == MODE_SW_IN);
      default: raw_status_o = edge_flag_reg;
    endcase
  end

  // Hardware mode hands value to the peripheral, and direction too once the pin's alternate function is selected
  always_comb begin
    if (mode_i == MODE_HW) begin
      drive_value = hw_out_i;
      drive_enable = hw_oe_i & alt_select_i;
    end else begin
      drive_value = sw_data_i;
      drive_enable = (mode_i == MODE_SW_OUT);
    end
  end

  // Open drain only ever pulls low
  assign pad_o = open_drain_i ? 1'b0 : drive_value;
  assign pad_oe_o = open_drain_i ? (drive_enable & ~drive_value) : drive_enable;
  assign level_o = sync2_reg;

endmodule // gpio_pin_slice

// file: design/gpio_port_pin_control.sv
/*
  GPIO port of up to eight pins: direction/mode, pad configuration, interrupt
  detection with enable and clear, masked data access, and conversion trigger.
  Assumes a single core clock, synchronous reset, and controls as plain ports
  driven from logic in the same clock domain; pads arrive asynchronously.
*/
module gpio_port_pin_control #(
  parameter int PINS = gpio_port_pkg::PIN_COUNT,
  parameter bit LEGACY_PULLUP = 1'b0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Multi-pin configuration command
  input wire logic cmd_valid_i,
  input wire gpio_port_pkg::command_type cmd_i,
  input wire logic [7:0] pin_select_mask_i,
  input wire logic [1:0] pin_direction_mode_i,
  input wire logic [2:0] int_type_i,
  input wire logic [1:0] drive_i,
  input wire logic weak_pullup_i,
  input wire logic weak_pulldown_i,
  input wire logic open_drain_i,
  // Single-pin readback
  input wire logic [2:0] single_pin_index_i,
  output logic [1:0] pin_direction_mode_o,
  output logic [2:0] int_type_o,
  output logic [1:0] drive_o,
  output logic weak_pullup_o,
  output logic weak_pulldown_o,
  output logic open_drain_o,
  output logic alt_select_o,
  output logic hardware_controlled_pin_o,
  // Address-masked data access
  input wire logic data_wr_i,
  input wire logic data_rd_i,
  input wire logic [gpio_port_pkg::DATA_ADDR_WIDTH-1:0] data_addr_i,
  input wire logic [7:0] data_wdata_i,
  output logic [7:0] data_rdata_o,
  output logic data_rvalid_o,
  // Interrupt status
  input wire logic status_masked_select_i,
  output logic [7:0] int_status_o,
  output logic int_o,
  // Conversion trigger
  output logic adc_trigger_o,
  // Peripheral side
  input wire logic [7:0] hw_out_i,
  input wire logic [7:0] hw_oe_i,
  output logic [7:0] hw_in_o,
  // Pads
  input wire logic [7:0] pad_i,
  output logic [7:0] pad_o,
  output logic [7:0] pad_oe_o,
  output logic [7:0] pad_drive_o,
  output logic [7:0] pad_slew_o,
  output logic [7:0] pad_pullup_o,
  output logic [7:0] pad_pulldown_o
);
  import gpio_port_pkg::*;

  logic [1:0] mode_reg [PINS];
  logic [2:0] detect_reg [PINS];
  logic [1:0] drive_reg [PINS];
  logic [7:0] pullup_reg;
  logic [7:0] pulldown_reg;
  logic [7:0] open_drain_reg;
  logic [7:0] alt_reg;
  logic [7:0] int_en_reg;
  logic [7:0] adc_en_reg;
  logic [7:0] data_reg;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic [7:0] level;
  logic [7:0] raw_status;
  logic [7:0] raw_status_prev_reg;
  logic [7:0] int_clear;
  logic [7:0] sel;
  logic [7:0] access_mask;
  logic [7:0] present;

  // Pins numbered PINS and above are not built and read as zero
  assign present = 8'(({8'h00, 8'hff} >> (8 - PINS)) & 16'h00ff);
  assign sel = pin_select_mask_i & present;
  assign access_mask = data_addr_i[MASK_ADDR_LSB +: 8] & present;
  // Clear acts in the command cycle; each slice lets a new edge win over it
  assign int_clear = (cmd_valid_i && cmd_i == CMD_INT_CLEAR) ? sel : 8'h00;

  // Direction and mode
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < PINS; i++) begin
      if (sys_rst_i) begin
        mode_reg[i] <= MODE_RESET;
      end else if (cmd_valid_i && cmd_i == CMD_DIR_MODE && sel[i]) begin
        mode_reg[i] <= pin_direction_mode_i;
      end
    end
  end

  // Interrupt detection type
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < PINS; i++) begin
      if (sys_rst_i) begin
        detect_reg[i] <= DETECT_RESET;
      end else if (cmd_valid_i && cmd_i == CMD_INT_TYPE && sel[i]) begin
        detect_reg[i] <= int_type_i;
      end
    end
  end

  // Pad configuration
  always_ff @(posedge core_clk_i) begin
    for (int i = 0; i < PINS; i++) begin
      if (sys_rst_i) begin
        drive_reg[i] <= DRIVE_RESET;
      end else if (cmd_valid_i && cmd_i == CMD_PAD_CFG && sel[i]) begin
        drive_reg[i] <= drive_i;
      end
    end
  end

  // Weak pulls; the older device class comes up with every built pin pulled up
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pullup_reg <= LEGACY_PULLUP ? present : MASK_RESET;
    end else if (cmd_valid_i && cmd_i == CMD_PAD_CFG) begin
      pullup_reg <= (pullup_reg & ~sel) | (sel & {8{weak_pullup_i}});
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pulldown_reg <= MASK_RESET;
    end else if (cmd_valid_i && cmd_i == CMD_PAD_CFG) begin
      pulldown_reg <= (pulldown_reg & ~sel) | (sel & {8{weak_pulldown_i}});
    end
  end

  // Open-drain type
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      open_drain_reg <= MASK_RESET;
    end else if (cmd_valid_i && cmd_i == CMD_PAD_CFG) begin
      open_drain_reg <= (open_drain_reg & ~sel) | (sel & {8{open_drain_i}});
    end
  end

  // Function select
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      alt_reg <= MASK_RESET;
    end else if (cmd_valid_i && cmd_i == CMD_ALT_SELECT) begin
      alt_reg <= alt_reg | sel;
    end else if (cmd_valid_i && cmd_i == CMD_GPIO_SELECT) begin
      alt_reg <= alt_reg & ~sel;
    end
  end

  // Interrupt enables
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      int_en_reg <= MASK_RESET;
    end else if (cmd_valid_i && cmd_i == CMD_INT_ENABLE) begin
      int_en_reg <= int_en_reg | sel;
    end else if (cmd_valid_i && cmd_i == CMD_INT_DISABLE) begin
      int_en_reg <= int_en_reg & ~sel;
    end
  end

  // Conversion trigger enables
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      adc_en_reg <= MASK_RESET;
    end else if (cmd_valid_i && cmd_i == CMD_ADC_ENABLE) begin
      adc_en_reg <= adc_en_reg | sel;
    end else if (cmd_valid_i && cmd_i == CMD_ADC_DISABLE) begin
      adc_en_reg <= adc_en_reg & ~sel;
    end
  end

  // Output data: one access writes every selected pin at once
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      data_reg <= DATA_RESET;
    end else if (data_wr_i) begin
      data_reg <= (data_reg & ~access_mask) | (data_wdata_i & access_mask);
    end
  end

  // Read data is registered so the answer comes one cycle after the request
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= data_rd_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rdata_reg <= DATA_RESET;
    end else if (data_rd_i) begin
      rdata_reg <= level & access_mask;
    end
  end

  // Trigger fires on the rising of a pin's status; sharing it with the interrupt
  // means trigger pins keep interrupting when enabled
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      raw_status_prev_reg <= MASK_RESET;
    end else begin
      raw_status_prev_reg <= raw_status;
    end
  end

  generate
    for (genvar g = 0; g < 8; g++) begin : g_pin
      if (g < PINS) begin : g_live
        gpio_pin_slice u_slice (
          .core_clk_i(core_clk_i),
          .sys_rst_i(sys_rst_i),
          .mode_i(mode_reg[g]),
          .detect_i(detect_reg[g]),
          .open_drain_i(open_drain_reg[g]),
          .sw_data_i(data_reg[g]),
          .hw_out_i(hw_out_i[g]),
          .hw_oe_i(hw_oe_i[g]),
          .alt_select_i(alt_reg[g]),
          .int_clear_i(int_clear[g]),
          .pad_i(pad_i[g]),
          .pad_o(pad_o[g]),
          .pad_oe_o(pad_oe_o[g]),
          .level_o(level[g]),
          .raw_status_o(raw_status[g])
        );
        // Only the 8 mA choice reaches the pad; 2 and 4 mA are told apart in readback
        assign pad_drive_o[g] = (drive_reg[g] == DRIVE_8MA) || (drive_reg[g] == DRIVE_8MA_SC);
        assign pad_slew_o[g] = (drive_reg[g] == DRIVE_8MA_SC);
      end else begin : g_absent
        assign pad_o[g] = 1'b0;
        assign pad_oe_o[g] = 1'b0;
        assign level[g] = 1'b0;
        assign raw_status[g] = 1'b0;
        assign pad_drive_o[g] = 1'b0;
        assign pad_slew_o[g] = 1'b0;
      end
    end
  endgenerate

  assign pad_pullup_o = pullup_reg;
  assign pad_pulldown_o = pulldown_reg;
  assign hw_in_o = level & alt_reg;
  assign data_rdata_o = rdata_reg;
  assign data_rvalid_o = rvalid_reg;

  assign int_status_o = status_masked_select_i ? (raw_status & int_en_reg) : raw_status;
  assign int_o = |(raw_status & int_en_reg);
  assign adc_trigger_o = |(raw_status & ~raw_status_prev_reg & adc_en_reg);

  // Single-pin readback by pin number
  always_comb begin
    pin_direction_mode_o = 2'h0;
    int_type_o = 3'h0;
    drive_o = 2'h0;
    if (32'(single_pin_index_i) < PINS) begin
      pin_direction_mode_o = mode_reg[single_pin_index_i];
      int_type_o = detect_reg[single_pin_index_i];
      drive_o = drive_reg[single_pin_index_i];
    end
  end

  // Bits of unbuilt pins are never set, so these read zero for them
  assign weak_pullup_o = pullup_reg[single_pin_index_i];
  assign weak_pulldown_o = pulldown_reg[single_pin_index_i];
  assign open_drain_o = open_drain_reg[single_pin_index_i];
  assign alt_select_o = alt_reg[single_pin_index_i];
  assign hardware_controlled_pin_o = (pin_direction_mode_o == MODE_HW);

endmodule // gpio_port_pin_control

// file: sim/gpio_pad_model.sv
/*
  Pad-side model: resolves each pin wire from block drive, outside drive and pulls.
  Assumes one outside driver per pin, enabled by the bench.
*/
module gpio_pad_model (
  // Clock
  input wire logic core_clk_i,
  // Block side
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_i,
  input wire logic [7:0] pu_i,
  input wire logic [7:0] pd_i,
  // Outside drivers
  input wire logic [7:0] ext_oe_i,
  input wire logic [7:0] ext_i,
  // Wire level
  output logic [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last_reg = 8'h00;
  always_ff @(posedge core_clk_i) begin
    last_reg <= level_o;
  end
  // A floating pin flips every cycle so a stale level is never mistaken for data
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (oe_i[i]) level_o[i] = drv_i[i];
      else if (ext_oe_i[i]) level_o[i] = ext_i[i];
      else if (pu_i[i]) level_o[i] = 1'b1;
      else if (pd_i[i]) level_o[i] = 1'b0;
      else level_o[i] = ~last_reg[i];
    end
  end
endmodule // gpio_pad_model

// file: sim/gpio_port_pin_control_sva.sv
/*
  Concurrent checks on the GPIO port pin-control top ports.
  Assumes one clock and a synchronous active-high reset.
*/
module gpio_port_pin_control_sva
  import gpio_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  // Commands and readback
  input wire logic cmd_valid_i,
  input wire gpio_port_pkg::command_type cmd_i,
  input wire logic [7:0] pin_select_mask_i,
  input wire logic [1:0] pin_direction_mode_i,
  input wire logic [2:0] int_type_i,
  input wire logic [2:0] single_pin_index_i,
  input wire logic [2:0] int_type_o,
  input wire logic alt_select_o,
  // Data access
  input wire logic data_rd_i,
  input wire logic [gpio_port_pkg::DATA_ADDR_WIDTH-1:0] data_addr_i,
  input wire logic [7:0] data_rdata_o,
  input wire logic data_rvalid_o,
  // Status and pads
  input wire logic status_masked_select_i,
  input wire logic [7:0] int_status_o,
  input wire logic int_o,
  input wire logic [7:0] hw_in_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [7:0] pad_drive_o,
  input wire logic [7:0] pad_slew_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd_req;
    data_rd_i;
  endsequence
  sequence s_rd_ans;
    data_rvalid_o && ((data_rdata_o & ~$past(data_addr_i[9:2])) == 8'h00);
  endsequence
  a_read_answer: assert property (s_rd_req |=> s_rd_ans)
    else $error("read answer late or unmasked");
  a_rvalid_cause: assert property (data_rvalid_o |-> $past(data_rd_i))
    else $error("read valid without a read");
  a_rdata_holds: assert property (!data_rd_i |=> $stable(data_rdata_o))
    else $error("read data moved without a read");
  a_int_any: assert property (status_masked_select_i |-> int_o == |int_status_o)
    else $error("interrupt output disagrees with masked status");
  a_slew_needs_8ma: assert property ((pad_slew_o & ~pad_drive_o) == 8'h00)
    else $error("slew control without 8 mA");
  a_reset_defaults: assert property (@(posedge core_clk_i) disable iff (1'b0)
    sys_rst_i |=> pad_oe_o == 8'h00 && pad_drive_o == 8'h00 && !int_o)
    else $error("pins not idle after reset");
  a_input_no_drive: assert property (cmd_valid_i && cmd_i == CMD_DIR_MODE &&
    pin_direction_mode_i == MODE_SW_IN |=> (pad_oe_o & $past(pin_select_mask_i)) == 8'h00)
    else $error("input pin still driven");
  a_type_readback: assert property (cmd_valid_i && cmd_i == CMD_INT_TYPE &&
    pin_select_mask_i[single_pin_index_i] ##1 $stable(single_pin_index_i)
    |-> int_type_o == $past(int_type_i))
    else $error("detection type readback wrong");
  a_alt_gates_in: assert property (!alt_select_o |-> !hw_in_o[single_pin_index_i])
    else $error("peripheral sees a GPIO pin");
endmodule // gpio_port_pin_control_sva

bind gpio_port_pin_control gpio_port_pin_control_sva u_sva (.*);

// file: sim/gpio_port_pin_control_tb.sv
/*
  Self-checking bench for the GPIO port pin control, driving its plain control ports.
  Assumes the pad model closes the pins; pin 1 is driven from outside.
*/
module gpio_port_pin_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import gpio_port_pkg::*;
  logic core_clk_i = 1'b0, sys_rst_i = 1'b1, cmd_valid_i = 1'b0;
  command_type cmd_i = CMD_NONE;
  logic [7:0] pin_select_mask_i = 8'h00, hw_out_i = 8'h00, hw_oe_i = 8'h00;
  logic [7:0] data_wdata_i = 8'h00, ext_oe = 8'h02, ext_val = 8'h00;
  logic [1:0] pin_direction_mode_i = 2'h0, drive_i = 2'h0;
  logic [2:0] int_type_i = 3'h0, single_pin_index_i = 3'h0;
  logic weak_pullup_i = 1'b0, weak_pulldown_i = 1'b0, open_drain_i = 1'b0;
  logic data_wr_i = 1'b0, data_rd_i = 1'b0, status_masked_select_i = 1'b0;
  logic [DATA_ADDR_WIDTH-1:0] data_addr_i = '0;
  logic [1:0] pin_direction_mode_o, drive_o;
  logic [2:0] int_type_o;
  logic weak_pullup_o, weak_pulldown_o, open_drain_o, alt_select_o, hardware_controlled_pin_o;
  logic data_rvalid_o, int_o, adc_trigger_o;
  logic [7:0] data_rdata_o, int_status_o, hw_in_o, pad_i, pad_o, pad_oe_o, pad_drive_o;
  logic [7:0] pad_slew_o, pad_pullup_o, pad_pulldown_o;
  logic [2:0] tyv [5] = '{DET_FALLING, DET_RISING, DET_BOTH, DET_LOW, DET_HIGH};
  int n_errors = 0, checks = 0;
  wire logic [11:0] rb = {pin_direction_mode_o, int_type_o, drive_o, weak_pullup_o,
    weak_pulldown_o, open_drain_o, alt_select_o, hardware_controlled_pin_o};

  gpio_port_pin_control #(.PINS(8), .LEGACY_PULLUP(1'b0)) uut (.*);
  gpio_pad_model pads (.core_clk_i(core_clk_i), .drv_i(pad_o), .oe_i(pad_oe_o),
    .pu_i(pad_pullup_o), .pd_i(pad_pulldown_o), .ext_oe_i(ext_oe), .ext_i(ext_val),
    .level_o(pad_i));

  always #4 core_clk_i = ~core_clk_i;

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One field word serves every command; each command reads only its own slice
  task automatic cmd(input command_type c, input logic [7:0] m, input logic [4:0] v);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= c;
    pin_select_mask_i <= m;
    pin_direction_mode_i <= v[1:0];
    drive_i <= v[1:0];
    int_type_i <= v[2:0];
    weak_pullup_i <= v[2];
    weak_pulldown_i <= v[3];
    open_drain_i <= v[4];
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] m, input logic [7:0] d);
    @(posedge core_clk_i);
    data_wr_i <= 1'b1;
    data_addr_i <= {m, 2'h0};
    data_wdata_i <= d;
    @(posedge core_clk_i);
    data_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] m, output logic [7:0] d);
    @(posedge core_clk_i);
    data_rd_i <= 1'b1;
    data_addr_i <= {m, 2'h0};
    @(posedge core_clk_i);
    data_rd_i <= 1'b0;
    #1;
    d = data_rdata_o;
    chk("rvalid", 12'h001, {11'h0, data_rvalid_o});
  endtask
  task automatic pulses(input int n, output int k);
    k = 0;
    repeat (n) begin
      tick(1);
      if (adc_trigger_o === 1'b1) k++;
    end
  endtask
  task automatic results();
    $display("Totals: %0d mismatches, %0d comparisons", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge core_clk_i);
    n_errors++;
    results();
  end

  initial begin
    logic [7:0] d;
    logic a;
    int k;
    repeat (2) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk_i);
      single_pin_index_i <= 3'(i);
      tick(1);
      chk("reset_readback", 12'h000, rb);
    end
    chk("reset_oe", 12'h000, {4'h0, pad_oe_o});
    cmd(CMD_DIR_MODE, 8'hff, 5'h01);
    wr(8'hff, 8'h00);
    wr(8'h09, 8'hff);
    tick(1);
    chk("pad_o", 12'h009, {4'h0, pad_o});
    chk("pad_oe", 12'h0ff, {4'h0, pad_oe_o});
    wr(8'hff, 8'ha5);
    tick(3);
    rd(8'h3c, d);
    chk("rdata", 12'h024, {4'h0, d});
    cmd(CMD_PAD_CFG, 8'h80, 5'h07);
    cmd(CMD_PAD_CFG, 8'h40, 5'h09);
    @(posedge core_clk_i);
    single_pin_index_i <= 3'h7;
    tick(1);
    chk("pin7_readback", 12'h470, rb);
    chk("pad_cfg", 12'h0a9, {4'h0, pad_drive_o[7:6], pad_slew_o[7:6], pad_pullup_o[7:6],
      pad_pulldown_o[7:6]});
    cmd(CMD_PAD_CFG, 8'h01, 5'h12);
    tick(1);
    chk("od_high", 12'h002, {9'h0, pad_oe_o[0], pad_drive_o[0], pad_slew_o[0]});
    wr(8'h01, 8'h00);
    tick(1);
    chk("od_low", 12'h002, {10'h0, pad_oe_o[0], pad_o[0]});
    cmd(CMD_DIR_MODE, 8'h04, 5'h02);
    cmd(CMD_ALT_SELECT, 8'h04, 5'h00);
    @(posedge core_clk_i);
    hw_oe_i <= 8'h04;
    single_pin_index_i <= 3'h2;
    tick(1);
    chk("hw_readback", 12'h803, rb);
    chk("hw_low", 12'h002, {10'h0, pad_oe_o[2], pad_o[2]});
    @(posedge core_clk_i);
    hw_out_i <= 8'h04;
    tick(1);
    chk("hw_high", 12'h003, {10'h0, pad_oe_o[2], pad_o[2]});
    tick(2);
    chk("hw_in", 12'h004, {4'h0, hw_in_o});
    cmd(CMD_GPIO_SELECT, 8'h04, 5'h00);
    tick(1);
    chk("gpio_select", 12'h000, {10'h0, pad_oe_o[2], alt_select_o});
    cmd(CMD_DIR_MODE, 8'h02, 5'h00);
    cmd(CMD_INT_ENABLE, 8'h02, 5'h00);
    @(posedge core_clk_i);
    single_pin_index_i <= 3'h1;
    for (int t = 0; t < 5; t++) begin
      a = (t == 0 || t == 3);
      @(posedge core_clk_i);
      ext_val[1] <= a;
      cmd(CMD_INT_TYPE, 8'h02, {2'h0, tyv[t]});
      tick(4);
      cmd(CMD_INT_CLEAR, 8'h02, 5'h00);
      tick(1);
      chk("status_idle", 12'h000, {11'h0, int_status_o[1]});
      @(posedge core_clk_i);
      ext_val[1] <= ~a;
      tick(4);
      chk("status_event", 12'h003, {10'h0, int_status_o[1], int_o});
      @(posedge core_clk_i);
      ext_val[1] <= a;
      tick(4);
      chk("status_after", {11'h0, t < 3}, {11'h0, int_status_o[1]});
    end
    @(posedge core_clk_i);
    ext_val[1] <= 1'b1;
    cmd(CMD_INT_DISABLE, 8'h02, 5'h00);
    @(posedge core_clk_i);
    status_masked_select_i <= 1'b1;
    tick(3);
    chk("masked", 12'h000, {10'h0, int_status_o[1], int_o});
    @(posedge core_clk_i);
    status_masked_select_i <= 1'b0;
    tick(1);
    chk("raw", 12'h001, {11'h0, int_status_o[1]});
    cmd(CMD_INT_TYPE, 8'h02, 5'h01);
    cmd(CMD_INT_ENABLE, 8'h02, 5'h00);
    for (int p = 0; p < 2; p++) begin
      cmd(p == 0 ? CMD_ADC_ENABLE : CMD_ADC_DISABLE, 8'h02, 5'h00);
      @(posedge core_clk_i);
      ext_val[1] <= 1'b0;
      tick(4);
      cmd(CMD_INT_CLEAR, 8'h02, 5'h00);
      @(posedge core_clk_i);
      ext_val[1] <= 1'b1;
      pulses(8, k);
      chk("adc_pulses", 12'(1 - p), 12'(k));
      chk("adc_int", 12'h001, {11'h0, int_o});
    end
    results();
  end
endmodule // gpio_port_pin_control_tb
